// ---- hw/sclt_link_tx.sv ----
// serial link transmit path: transport, link layer, registers, alarms
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Summary of operation
// RL1: samples packed into octets, frames, multiframes by mode and K.
// RL2: scramble enable bit scrambles data octets; off unless set.
// RL3: alignment sequence is never scrambled.
// RL4: while sync is low every octet sent is the comma K28.5.
// RL5: receiver asserts sync, locks on four commas, releases on LMFC.
// RL6: after sync release, wait for next LMFC edge before alignment.
// RL7: alignment sequence spans exactly four multiframes of fixed pattern.
// RL8: second alignment multiframe carries the link configuration.
// RL9: receiver buffers lanes and releases them together.
// RL10: every octet becomes a 10-bit character with running disparity.
// RL11: unscrambled repeated frame-final octet becomes K28.7, or K28.3.
// RL12: scrambled frame-final 0xFC becomes K28.7, multiframe-final K28.3.
// RL13: receiver checks alignment characters and restores data.
// RL14: link enable at 0 holds block in reset and serializer off.
// RL15: larger pre-emphasis value gives stronger pre-emphasis.
// RL16: captured SYSREF resets the local multiframe counters.
// RL17: receiver picks its buffer release delay from the LMFC.
// RL18: receiver releases buffers only when all lanes arrived.
// RL19: without SYSREF the LMFC free-runs; sync still drives startup.
// RL20: five alarm sources are detected.
// RL21: each alarm sets a sticky flag cleared by writing one.
// RL22: unmasked alarm sets summary and, if selected, the status pin.
// RL23: data follows the fourth multiframe; sync low returns to commas.
module sclt_link_tx (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [15:0] i_sample,
  output logic o_sample_ready,
  input wire logic i_sync_n,
  input wire logic i_sysref,
  input wire logic i_pll_locked,
  input wire logic i_nco_upset,
  input wire logic i_clk_upset,
  output logic [9:0] o_char,
  output logic o_ser_powerdown,
  output logic [7:0] o_preemphasis_level,
  output logic o_alarm,
  output logic o_status_output_pin
);
  // reset release through two flops
  logic rst_q1;
  logic rst_q2;
  logic rst_n;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  assign rst_n = rst_q2;

  // pin synchronisers; logic reads the second stage, and sysref also a third stage for its edge
  logic [4:0] pin_q1;
  logic [4:0] pin_q2;
  logic sref_q3;
  logic [4:0] pin_raw;

  assign pin_raw = {i_clk_upset, i_nco_upset, i_pll_locked, i_sysref,
                    i_sync_n};

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_q1 <= sclt_pkg::PIN_IDLE;
      pin_q2 <= sclt_pkg::PIN_IDLE;
      sref_q3 <= 1'b0;
    end else begin
      pin_q1 <= pin_raw;
      pin_q2 <= pin_q1;
      sref_q3 <= pin_q2[sclt_pkg::PIN_SYSREF];
    end
  end

  logic sync_low;
  logic sref_event;

  assign sync_low = !pin_q2[sclt_pkg::PIN_SYNC_N];
  assign sref_event = pin_q2[sclt_pkg::PIN_SYSREF] & ~sref_q3;

  // register file
  logic [7:0] emph_q, emph_d;
  logic [7:0] en_q, en_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] km1_q, km1_d;
  logic [7:0] ctl_q, ctl_d;
  logic [4:0] flags_q, flags_d;
  logic [4:0] mask_q, mask_d;
  logic [7:0] pinsel_q, pinsel_d;
  logic [7:0] rdata_q, rdata_d;
  logic alarm_q, alarm_d;
  logic stpin_q, stpin_d;
  logic [4:0] alm_event;
  sclt_pkg::sclt_state_type state_q, state_d;

  logic enabled;
  logic scr_on;
  logic sub1_on;

  assign enabled = en_q[0];
  assign scr_on = ctl_q[sclt_pkg::CTL_SCR_BIT];
  assign sub1_on = ctl_q[sclt_pkg::CTL_SUB1_BIT];

  always_comb begin
    logic [4:0] clr;
    emph_d = emph_q;
    en_d = en_q;
    mode_d = mode_q;
    km1_d = km1_q;
    ctl_d = ctl_q;
    mask_d = mask_q;
    pinsel_d = pinsel_q;
    clr = 5'h00;
    if (i_wr) begin
      case (i_addr)
        sclt_pkg::ADDR_EMPH: emph_d = i_wdata; // [RL15]
        sclt_pkg::ADDR_ENABLE: en_d = {7'h00, i_wdata[0]};
        // link parameters only move while the link is off
        sclt_pkg::ADDR_MODE: if (!enabled) mode_d = i_wdata; // [RL14]
        sclt_pkg::ADDR_KM1: if (!enabled) km1_d = {3'h0, i_wdata[4:0]};
        sclt_pkg::ADDR_CTL: if (!enabled) ctl_d = {6'h00, i_wdata[1:0]};
        sclt_pkg::ADDR_FLAGS: clr = i_wdata[4:0];
        sclt_pkg::ADDR_MASK: mask_d = i_wdata[4:0];
        sclt_pkg::ADDR_PINSEL: pinsel_d = {7'h00, i_wdata[0]};
        default: ;
      endcase
    end
    // a new event beats a clear in the same cycle
    flags_d = (flags_q & ~clr) | alm_event; // [RL21]
    alarm_d = |(flags_q & ~mask_q); // [RL22]
    stpin_d = alarm_d & pinsel_q[0]; // [RL22]
    rdata_d = 8'h00;
    if (i_rd) begin
      case (i_addr)
        sclt_pkg::ADDR_EMPH: rdata_d = emph_q;
        sclt_pkg::ADDR_ENABLE: rdata_d = en_q;
        sclt_pkg::ADDR_MODE: rdata_d = mode_q;
        sclt_pkg::ADDR_KM1: rdata_d = km1_q;
        sclt_pkg::ADDR_CTL: rdata_d = ctl_q;
        sclt_pkg::ADDR_FLAGS: rdata_d = {3'h0, flags_q};
        sclt_pkg::ADDR_MASK: rdata_d = {3'h0, mask_q};
        sclt_pkg::ADDR_STATUS: rdata_d = {5'h00, state_q, alarm_q};
        sclt_pkg::ADDR_PINSEL: rdata_d = pinsel_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      emph_q <= sclt_pkg::RST_EMPH;
      en_q <= sclt_pkg::RST_ENABLE;
      mode_q <= sclt_pkg::RST_MODE;
      km1_q <= sclt_pkg::RST_KM1;
      ctl_q <= sclt_pkg::RST_CTL;
      flags_q <= 5'h00;
      mask_q <= sclt_pkg::RST_MASK;
      pinsel_q <= sclt_pkg::RST_PINSEL;
      rdata_q <= 8'h00;
      alarm_q <= 1'b0;
      stpin_q <= 1'b0;
    end else begin
      emph_q <= emph_d;
      en_q <= en_d;
      mode_q <= mode_d;
      km1_q <= km1_d;
      ctl_q <= ctl_d;
      flags_q <= flags_d;
      mask_q <= mask_d;
      pinsel_q <= pinsel_d;
      rdata_q <= rdata_d;
      alarm_q <= alarm_d;
      stpin_q <= stpin_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_preemphasis_level = emph_q; // [RL15]
  assign o_ser_powerdown = ~enabled; // [RL14]
  assign o_alarm = alarm_q;
  assign o_status_output_pin = stpin_q;

  // link layer: multiframe counters, sequencing, octet selection
  logic [1:0] oct_q, oct_d;
  logic [4:0] fr_q, fr_d;
  logic [1:0] ilas_q, ilas_d;
  logic [7:0] low_q, low_d;
  logic [7:0] last_q, last_d;
  logic [1:0] f_last;
  logic frame_end;
  logic mf_end;
  logic sref_hit;
  logic [6:0] pos;
  logic [7:0] tx_octet;
  logic tx_k;
  logic [7:0] raw_octet;
  logic [7:0] scr_octet;
  logic [7:0] fin_octet;
  logic scr_clear;
  logic scr_adv;

  // wide mode sends two samples per frame
  assign f_last = mode_q[sclt_pkg::MODE_WIDE_BIT] ? 2'h3 : 2'h1; // [RL1]
  assign frame_end = (oct_q == f_last); // [RL1]
  assign mf_end = frame_end && (fr_q == km1_q[4:0]); // [RL1]
  assign sref_hit = enabled && sub1_on && sref_event; // [RL16]
  assign pos = mode_q[sclt_pkg::MODE_WIDE_BIT] ? {fr_q, oct_q}
                                               : {1'b0, fr_q, oct_q[0]};
  // each sample goes out as two octets, high byte first
  assign o_sample_ready = enabled && (state_q == sclt_pkg::ST_DATA)
                          && !oct_q[0]; // [RL1]
  assign raw_octet = oct_q[0] ? low_q : i_sample[15:8]; // [RL1]
  assign scr_clear = !enabled || (state_q != sclt_pkg::ST_DATA);
  // scrambler only steps on data octets, never on alignment
  assign scr_adv = scr_on && (state_q == sclt_pkg::ST_DATA); // [RL3]
  assign fin_octet = scr_on ? scr_octet : raw_octet; // [RL2]

  sclt_scrambler u_scr (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_clear(scr_clear),
    .i_advance(scr_adv),
    .i_data(raw_octet),
    .o_data(scr_octet)
  );

  always_comb begin
    oct_d = oct_q;
    fr_d = fr_q;
    state_d = state_q;
    ilas_d = ilas_q;
    low_d = low_q;
    last_d = last_q;
    // counters free-run without SYSREF, so the LMFC phase is arbitrary
    if (!enabled || sref_hit) begin // [RL14] [RL16] [RL19]
      oct_d = 2'h0;
      fr_d = 5'h00;
    end else if (frame_end) begin
      oct_d = 2'h0;
      fr_d = mf_end ? 5'h00 : fr_q + 5'h01;
    end else begin
      oct_d = oct_q + 2'h1;
    end
    case (state_q)
      sclt_pkg::ST_CGS: begin
        if (!sync_low) state_d = sclt_pkg::ST_WAIT;
      end
      sclt_pkg::ST_WAIT: begin
        if (mf_end) begin // [RL6]
          state_d = sclt_pkg::ST_ILAS;
          ilas_d = 2'h0;
        end
      end
      sclt_pkg::ST_ILAS: begin
        if (mf_end) begin
          if (ilas_q == sclt_pkg::ILAS_LAST) state_d = sclt_pkg::ST_DATA; // [RL7] [RL23]
          else ilas_d = ilas_q + 2'h1;
        end
      end
      sclt_pkg::ST_DATA: begin
        if (o_sample_ready) low_d = i_sample[7:0];
        if (frame_end) last_d = fin_octet;
      end
      default: state_d = sclt_pkg::ST_CGS;
    endcase
    if (!enabled || sync_low) begin // [RL4] [RL14] [RL23]
      state_d = sclt_pkg::ST_CGS;
      ilas_d = 2'h0;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      oct_q <= 2'h0;
      fr_q <= 5'h00;
      state_q <= sclt_pkg::ST_CGS;
      ilas_q <= 2'h0;
      low_q <= 8'h00;
      last_q <= 8'h00;
    end else begin
      oct_q <= oct_d;
      fr_q <= fr_d;
      state_q <= state_d;
      ilas_q <= ilas_d;
      low_q <= low_d;
      last_q <= last_d;
    end
  end

  // octet and k flag handed to the encoder
  always_comb begin
    tx_octet = sclt_pkg::K_COMMA;
    tx_k = 1'b1;
    case (state_q)
      sclt_pkg::ST_CGS, sclt_pkg::ST_WAIT: begin
        tx_octet = sclt_pkg::K_COMMA; // [RL4]
        tx_k = 1'b1;
      end
      sclt_pkg::ST_ILAS: begin
        // fixed pattern: start mark, ramp, end mark
        tx_k = 1'b0;
        tx_octet = {1'b0, pos}; // [RL7]
        if (pos == 7'h00) begin
          tx_octet = sclt_pkg::K_MF_START; // [RL7]
          tx_k = 1'b1;
        end else if (mf_end) begin
          tx_octet = sclt_pkg::K_MF_ALIGN; // [RL7]
          tx_k = 1'b1;
        end else if (ilas_q == sclt_pkg::ILAS_CFG_MF) begin
          case (pos)
            7'h01: begin
              tx_octet = sclt_pkg::K_CFG_START; // [RL8]
              tx_k = 1'b1;
            end
            sclt_pkg::CFG_POS_F: tx_octet = {6'h00, f_last}; // [RL8]
            sclt_pkg::CFG_POS_K: tx_octet = km1_q; // [RL8]
            sclt_pkg::CFG_POS_MODE: tx_octet = mode_q; // [RL8]
            sclt_pkg::CFG_POS_CTL: tx_octet = ctl_q; // [RL8]
            default: tx_octet = {1'b0, pos};
          endcase
        end
      end
      sclt_pkg::ST_DATA: begin
        tx_octet = fin_octet; // [RL2]
        tx_k = 1'b0;
        if (frame_end && (scr_on ? (fin_octet == sclt_pkg::SCR_MARK)
                                 : (fin_octet == last_q))) begin // [RL11] [RL12]
          tx_octet = mf_end ? sclt_pkg::K_MF_ALIGN : sclt_pkg::K_FR_ALIGN;
          tx_k = 1'b1;
        end
      end
      default: begin
        tx_octet = sclt_pkg::K_COMMA;
        tx_k = 1'b1;
      end
    endcase
  end

  sclt_enc8b10b u_enc (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_clear(!enabled),
    .i_data(tx_octet),
    .i_k(tx_k),
    .o_char(o_char) // [RL10]
  );

  // alarm sources
  always_comb begin
    alm_event = 5'h00;
    alm_event[sclt_pkg::ALM_PLL] = !pin_q2[sclt_pkg::PIN_PLL]; // [RL20]
    alm_event[sclt_pkg::ALM_LINK] = (state_q != sclt_pkg::ST_DATA); // [RL20]
    // realigned only when the counters were not already at a boundary
    alm_event[sclt_pkg::ALM_SREF] = sref_hit && !mf_end; // [RL20]
    alm_event[sclt_pkg::ALM_NCO] = pin_q2[sclt_pkg::PIN_NCO]; // [RL20]
    alm_event[sclt_pkg::ALM_CLK] = pin_q2[sclt_pkg::PIN_CLK]; // [RL20]
  end
endmodule : sclt_link_tx

// ---- hw/sclt_pkg.sv ----
// shared constants, tables and types of the serial link transmitter
package sclt_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_EMPH = 12'h048;
  localparam logic [11:0] ADDR_ENABLE = 12'h200;
  localparam logic [11:0] ADDR_MODE = 12'h201;
  localparam logic [11:0] ADDR_KM1 = 12'h202;
  localparam logic [11:0] ADDR_CTL = 12'h204;
  localparam logic [11:0] ADDR_FLAGS = 12'h208;
  localparam logic [11:0] ADDR_MASK = 12'h209;
  localparam logic [11:0] ADDR_STATUS = 12'h20A;
  localparam logic [11:0] ADDR_PINSEL = 12'h20C;
  // values after reset
  localparam logic [7:0] RST_EMPH = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h01;
  localparam logic [7:0] RST_MODE = 8'h02;
  localparam logic [7:0] RST_KM1 = 8'h1F;
  localparam logic [7:0] RST_CTL = 8'h02;
  localparam logic [4:0] RST_MASK = 5'h00;
  localparam logic [7:0] RST_PINSEL = 8'h00;
  // field positions
  localparam int CTL_SCR_BIT = 0;
  localparam int CTL_SUB1_BIT = 1;
  localparam int MODE_WIDE_BIT = 0;
  localparam int ALM_PLL = 0;
  localparam int ALM_LINK = 1;
  localparam int ALM_SREF = 2;
  localparam int ALM_NCO = 3;
  localparam int ALM_CLK = 4;
  localparam int ALM_W = 5;
  // synchronised pins: sync_n, sysref, pll_locked, nco, clk upset
  localparam int PIN_SYNC_N = 0;
  localparam int PIN_SYSREF = 1;
  localparam int PIN_PLL = 2;
  localparam int PIN_NCO = 3;
  localparam int PIN_CLK = 4;
  localparam logic [4:0] PIN_IDLE = 5'h04;
  // control characters (octet form, sent with the k flag)
  localparam logic [7:0] K_COMMA = 8'hBC;
  localparam logic [7:0] K_MF_START = 8'h1C;
  localparam logic [7:0] K_CFG_START = 8'h9C;
  localparam logic [7:0] K_MF_ALIGN = 8'h7C;
  localparam logic [7:0] K_FR_ALIGN = 8'hFC;
  localparam logic [7:0] SCR_MARK = 8'hFC;
  // alignment sequence layout
  localparam logic [1:0] ILAS_LAST = 2'h3;
  localparam logic [1:0] ILAS_CFG_MF = 2'h1;
  localparam logic [6:0] CFG_POS_F = 7'h02;
  localparam logic [6:0] CFG_POS_K = 7'h03;
  localparam logic [6:0] CFG_POS_MODE = 7'h04;
  localparam logic [6:0] CFG_POS_CTL = 7'h05;
  localparam logic [14:0] SCR_SEED = 15'h7FFF;
  // 8b/10b tables, negative running disparity, abcdei and fghj
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] T4 [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
  localparam logic [5:0] K28_6B = 6'h0F;
  localparam logic [5:0] D07_6B = 6'h38;
  localparam logic [3:0] A7_4B = 4'h7;
  localparam logic [3:0] D3_4B = 4'hC;
  typedef enum logic [1:0] {
    ST_CGS, ST_WAIT, ST_ILAS, ST_DATA
  } sclt_state_type;
endpackage : sclt_pkg

// ---- hw/sclt_scrambler.sv ----
// self-synchronising octet scrambler, polynomial 1 + x^14 + x^15
`timescale 1ns/1ps
module sclt_scrambler (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_advance,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data
);
  logic [14:0] st_q;
  logic [14:0] st_d;

  // msb first; s[0] holds the newest scrambled bit
  always_comb begin
    logic [14:0] s;
    logic b;
    s = st_q;
    b = 1'b0;
    o_data = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      b = i_data[i] ^ s[13] ^ s[14];
      o_data[i] = b;
      s = {s[13:0], b};
    end
    st_d = i_clear ? sclt_pkg::SCR_SEED : (i_advance ? s : st_q);
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) st_q <= sclt_pkg::SCR_SEED;
    else st_q <= st_d;
  end
endmodule : sclt_scrambler

// ---- hw/sclt_enc8b10b.sv ----
// 8b/10b encoder with running disparity, registered character out
`timescale 1ns/1ps
module sclt_enc8b10b (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic [7:0] i_data,
  input wire logic i_k,
  output logic [9:0] o_char
);
  logic rd_q;
  logic rd_d;
  logic [9:0] char_q;
  logic [9:0] char_d;

  always_comb begin
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] c6;
    logic [3:0] c4;
    logic rd1;
    logic alt;
    x = i_data[4:0];
    y = i_data[7:5];
    rd1 = 1'b0;
    alt = 1'b0;
    c4 = 4'h0;
    c6 = i_k ? sclt_pkg::K28_6B : sclt_pkg::T6[x];
    if (rd_q && ($countones(c6) != 3 || c6 == sclt_pkg::D07_6B)) c6 = ~c6;
    rd1 = ($countones(c6) != 3) ? ~rd_q : rd_q;
    // alternate x.7 avoids a run of five equal bits across the boundary
    alt = (y == 3'h7) && (i_k
      || (!rd1 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
      || (rd1 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
    c4 = alt ? sclt_pkg::A7_4B : sclt_pkg::T4[y];
    if (i_k && !rd1 && (y == 3'h1 || y == 3'h2 || y == 3'h5 || y == 3'h6))
      c4 = ~c4;
    if (rd1 && ($countones(c4) != 2 || c4 == sclt_pkg::D3_4B)) c4 = ~c4;
    rd_d = ($countones(c4) != 2) ? ~rd1 : rd1;
    char_d = {c6, c4};
    if (i_clear) begin
      rd_d = 1'b0;
      char_d = 10'h000;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_q <= 1'b0;
      char_q <= 10'h000;
    end else begin
      rd_q <= rd_d;
      char_q <= char_d;
    end
  end

  assign o_char = char_q;
endmodule : sclt_enc8b10b

// ---- tb/sclt_link_tx_props.sv ----
// port-level assertions and covers for the link transmitter
`timescale 1ns/1ps
module sclt_link_tx_chk (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [15:0] i_sample,
  input wire logic o_sample_ready,
  input wire logic i_sync_n,
  input wire logic i_sysref,
  input wire logic i_pll_locked,
  input wire logic i_nco_upset,
  input wire logic i_clk_upset,
  input wire logic [9:0] o_char,
  input wire logic o_ser_powerdown,
  input wire logic [7:0] o_preemphasis_level,
  input wire logic o_alarm,
  input wire logic o_status_output_pin
);
  // comma code in either running disparity
  localparam logic [9:0] COMMA_NEG = 10'h0FA;
  localparam logic [9:0] COMMA_POS = 10'h305;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  // eight cycles cover pin sync, state and encoder latency
  a_comma_in_sync: assert property (
    (!i_sync_n && !o_ser_powerdown) [*8] |->
    (o_char == COMMA_NEG || o_char == COMMA_POS))
    else $error("comma stream missing while sync is low");
  a_no_early_data: assert property (
    $rose(i_sync_n) |-> !o_sample_ready [*8])
    else $error("data began before the alignment sequence");
  a_sync_stops_data: assert property (
    !i_sync_n [*5] |-> !o_sample_ready)
    else $error("data still flowing after sync went low");
  a_ready_alternates: assert property (
    o_sample_ready |=> !o_sample_ready)
    else $error("sample taken on two octets in a row");
  a_enable_powerdown: assert property (
    i_wr && i_addr == sclt_pkg::ADDR_ENABLE |=>
    o_ser_powerdown != $past(i_wdata[0]))
    else $error("serializer power state does not follow enable");
  a_down_is_quiet: assert property (
    o_ser_powerdown [*2] |-> o_char == 10'h000 && !o_sample_ready)
    else $error("link active while disabled");
  a_emph_update: assert property (
    i_wr && i_addr == sclt_pkg::ADDR_EMPH |=>
    o_preemphasis_level == $past(i_wdata))
    else $error("pre-emphasis level not taken from write");
  a_pin_needs_alarm: assert property (
    o_status_output_pin |-> o_alarm)
    else $error("status pin high without summary alarm");
  c_data: cover property (o_sample_ready);
  c_pin: cover property (o_status_output_pin);
  c_down: cover property ($rose(o_ser_powerdown));
endmodule : sclt_link_tx_chk

bind sclt_link_tx sclt_link_tx_chk i_chk (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_sample(i_sample), .o_sample_ready(o_sample_ready),
  .i_sync_n(i_sync_n), .i_sysref(i_sysref), .i_pll_locked(i_pll_locked),
  .i_nco_upset(i_nco_upset), .i_clk_upset(i_clk_upset),
  .o_char(o_char), .o_ser_powerdown(o_ser_powerdown),
  .o_preemphasis_level(o_preemphasis_level), .o_alarm(o_alarm),
  .o_status_output_pin(o_status_output_pin)
);

// ---- tb/sclt_rx_model.sv ----
// receiver stand-in: sync from comma lock and its own multiframe count
`timescale 1ns/1ps
module sclt_rx_model #(
  parameter int LMFC_LEN = 4,
  parameter int RELEASE_BUFFER_DELAY = 0
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [9:0] i_char,
  input wire logic i_hold,
  input wire logic i_resync,
  output logic o_sync_n = 1'b0,
  output logic o_released = 1'b0,
  output logic o_misplaced = 1'b0
);
  int commas = 0;
  int lmfc = 0;
  int mf_pos = 0;
  logic mf_start;
  logic mf_align;
  logic lane_seen = 1'b0;

  // K28.0 and K28.3 in either running disparity
  assign mf_start = (i_char == 10'h0F4 || i_char == 10'h30B);
  assign mf_align = (i_char == 10'h0F3 || i_char == 10'h30C);

  // lmfc phase is arbitrary against the transmitter, as on real boards
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sync_n <= 1'b0;
      o_released <= 1'b0;
      o_misplaced <= 1'b0;
      lane_seen <= 1'b0;
      commas <= 0;
      lmfc <= 0;
      mf_pos <= 0;
    end else begin
      lmfc <= (lmfc + 1) % LMFC_LEN;
      // a start marker re-bases the receive multiframe position
      mf_pos <= mf_start ? 1 : (mf_pos + 1) % LMFC_LEN;
      if (mf_align && mf_pos != LMFC_LEN - 1) begin
        o_misplaced <= 1'b1;
      end
      if (i_char == 10'h0FA || i_char == 10'h305) begin
        commas <= (commas < 4) ? commas + 1 : 4;
      end else begin
        commas <= 0;
      end
      if (i_resync) begin
        o_sync_n <= 1'b0;
        o_released <= 1'b0;
        lane_seen <= 1'b0;
      end else begin
        if (!o_sync_n && commas >= 4 && lmfc == 0 && !i_hold) begin
          o_sync_n <= 1'b1;
        end
        // lane held from its start marker until the release point
        if (mf_start) lane_seen <= 1'b1;
        if (lane_seen && lmfc == RELEASE_BUFFER_DELAY) begin
          o_released <= 1'b1;
        end
      end
    end
  end
endmodule : sclt_rx_model

// ---- tb/tb_top.sv ----
// self-checking bench for the link transmitter
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
      num_errors++; \
      $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb_top;
  logic i_clock;
  logic i_nrst;
  logic [11:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [7:0] o_rdata;
  logic [15:0] i_sample;
  logic o_sample_ready;
  logic i_sync_n;
  logic i_sysref;
  logic i_pll_locked;
  logic i_nco_upset;
  logic i_clk_upset;
  logic [9:0] o_char;
  logic o_ser_powerdown;
  logic [7:0] o_preemphasis_level;
  logic o_alarm;
  logic o_status_output_pin;
  logic rx_hold;
  logic rx_resync;
  logic rx_released;
  logic rx_misplaced;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  logic [11:0] adr_q[$];
  logic [7:0] ev;
  logic [11:0] ea;
  logic [7:0] d;
  int num_errors = 0;
  int samples_checked = 0;
  int n;
  localparam logic [7:0] FLAG_TBL [3] = '{8'h01, 8'h08, 8'h10};

  sclt_link_tx i_dut (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_sample(i_sample), .o_sample_ready(o_sample_ready),
    .i_sync_n(i_sync_n), .i_sysref(i_sysref), .i_pll_locked(i_pll_locked),
    .i_nco_upset(i_nco_upset), .i_clk_upset(i_clk_upset),
    .o_char(o_char), .o_ser_powerdown(o_ser_powerdown),
    .o_preemphasis_level(o_preemphasis_level), .o_alarm(o_alarm),
    .o_status_output_pin(o_status_output_pin)
  );
  sclt_rx_model #(.LMFC_LEN(4)) i_rx (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_char(o_char),
    .i_hold(rx_hold), .i_resync(rx_resync), .o_sync_n(i_sync_n),
    .o_released(rx_released), .o_misplaced(rx_misplaced)
  );

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    i_sample <= 16'($urandom());
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
  endtask : wr

  // the expectation is noted here and judged by the read monitor
  task automatic rd(input logic [11:0] a, input logic [7:0] v);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back(v);
    adr_q.push_back(a);
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(posedge i_clock);
  endtask : rd

  // bounded wait, n returns the cycles spent
  task automatic wait_ready();
    n = 0;
    while (o_sample_ready !== 1'b1 && n < 200) begin
      @(posedge i_clock);
      n++;
    end
  endtask : wait_ready

  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  always @(posedge i_clock) begin
    rd_seen <= i_rd;
    if (rd_seen === 1'b1) begin
      ev = exp_q.pop_front();
      ea = adr_q.pop_front();
      `CHK($sformatf("rdata_%h", ea), ev, o_rdata)
    end
  end

  initial begin
    #20000;
    num_errors++;
    $display("MISMATCH run_time expected %h seen %h", 1'b1, 1'b0);
    give_verdict();
  end

  initial begin
    void'($urandom(31729));
    i_nrst = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_sample = '0;
    i_sysref = 1'b0;
    i_pll_locked = 1'b1;
    i_nco_upset = 1'b0;
    i_clk_upset = 1'b0;
    rx_hold = 1'b1;
    rx_resync = 1'b0;
    repeat (6) @(posedge i_clock);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clock);
    rd(sclt_pkg::ADDR_EMPH, 8'h00);
    rd(sclt_pkg::ADDR_ENABLE, 8'h01);
    rd(sclt_pkg::ADDR_CTL, 8'h02);
    rd(sclt_pkg::ADDR_MODE, 8'h02);
    rd(sclt_pkg::ADDR_KM1, 8'h1F);
    rd(12'h300, 8'h00);
    d = 8'($urandom());
    wr(sclt_pkg::ADDR_EMPH, d);
    `CHK("preemphasis", d, o_preemphasis_level)
    rd(sclt_pkg::ADDR_EMPH, d);
    wr(sclt_pkg::ADDR_CTL, 8'h01);
    rd(sclt_pkg::ADDR_CTL, 8'h02);
    wr(sclt_pkg::ADDR_ENABLE, 8'h00);
    `CHK("powerdown", 1'b1, o_ser_powerdown)
    wr(sclt_pkg::ADDR_KM1, 8'h01);
    wr(sclt_pkg::ADDR_MODE, 8'h00);
    wr(sclt_pkg::ADDR_CTL, 8'h03);
    rd(sclt_pkg::ADDR_KM1, 8'h01);
    rd(sclt_pkg::ADDR_CTL, 8'h03);
    wr(sclt_pkg::ADDR_ENABLE, 8'h01);
    `CHK("powerdown", 1'b0, o_ser_powerdown)
    // two sysref edges two cycles apart: the second lands mid-multiframe
    wr(sclt_pkg::ADDR_FLAGS, 8'h1F);
    repeat (2) begin
      i_sysref <= 1'b1;
      @(posedge i_clock);
      i_sysref <= 1'b0;
      @(posedge i_clock);
    end
    repeat (6) @(posedge i_clock);
    rd(sclt_pkg::ADDR_FLAGS, 8'h06);
    repeat (20) @(posedge i_clock);
    rx_hold <= 1'b0;
    n = 0;
    while (i_sync_n !== 1'b1 && n < 100) begin
      @(posedge i_clock);
      n++;
    end
    wait_ready();
    `CHK("ilas_span", 1'b1, n >= 20 && n <= 23)
    wr(sclt_pkg::ADDR_FLAGS, 8'h1F);
    rd(sclt_pkg::ADDR_FLAGS, 8'h00);
    rd(sclt_pkg::ADDR_STATUS, 8'h06);
    wr(sclt_pkg::ADDR_MASK, 8'h10);
    wr(sclt_pkg::ADDR_PINSEL, 8'h01);
    for (int k = 0; k < 3; k++) begin
      i_pll_locked <= (k != 0);
      i_nco_upset <= (k == 1);
      i_clk_upset <= (k == 2);
      repeat (4) @(posedge i_clock);
      i_pll_locked <= 1'b1;
      i_nco_upset <= 1'b0;
      i_clk_upset <= 1'b0;
      repeat (4) @(posedge i_clock);
      rd(sclt_pkg::ADDR_FLAGS, FLAG_TBL[k]);
      `CHK("alarm", k != 2, o_alarm)
      `CHK("status_pin", k != 2, o_status_output_pin)
      wr(sclt_pkg::ADDR_FLAGS, 8'h1F);
      rd(sclt_pkg::ADDR_FLAGS, 8'h00);
    end
    rx_resync <= 1'b1;
    repeat (12) @(posedge i_clock);
    rd(sclt_pkg::ADDR_STATUS, 8'h01);
    rx_resync <= 1'b0;
    wait_ready();
    `CHK("relink", 1'b1, o_sample_ready)
    `CHK("rx_release", 1'b1, rx_released)
    // second bring-up: four octets a frame, no scrambling, no SYSREF use
    wr(sclt_pkg::ADDR_ENABLE, 8'h00);
    wr(sclt_pkg::ADDR_MODE, 8'h01);
    wr(sclt_pkg::ADDR_CTL, 8'h00);
    wr(sclt_pkg::ADDR_ENABLE, 8'h01);
    wait_ready();
    `CHK("wide_link", 1'b1, o_sample_ready)
    `CHK("align_place", 1'b0, rx_misplaced)
    give_verdict();
  end
endmodule : tb_top
